// [verilog/fdrf_core.sv]
/*
 * Floppy controller host register bank: data port with 16-byte
 * execution buffer, service requests, input register and rate control.
 * Assumes an APB master on pclk, a command sequencer on the same clock,
 * and an asynchronous disk change pin.
 */
// Local design decisions: register access over APB and the register addresses.
// Operation
// - Rate code selects bit rate
// - One data port for all phases
// - Buffer only in execution phase
// - Lock keeps buffer over soft reset
// - Hard reset: buffer off, threshold zero
// - Burst request holds until done
// - Non-burst request gaps 350 ns
// - Buffer off per direction
// - DMA, interrupt and polling all work
// - Legacy layout drives only bit 7
// - Second layout: change, ones, rate, density
// - Density low for 1M/500k, else high
// - Third layout: inverted change, dma, no_precomp_bit
// - Change bit undefined while powered down
// - Soft reset spares input register
// - Config keeps soft, resets to 250k
// - Latest rate write wins
// - No-precomp bit stored, reflected, kept
// - Request flag clears after byte
// - Direction flag shows transfer way
// - Rate select survives soft reset
`timescale 1ns/1ps
`include "fdrf_regs.svh"
module fdrf_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic disk_change_input,
    input wire logic power_down,
    input wire logic dma_enable_bit,
    input wire logic fm_mode,
    input wire fdrf_pkg::fdrf_mode_t compat_mode,
    input wire fdrf_pkg::fdrf_phase_t seq_phase,
    input wire logic seq_dir,
    input wire fdrf_pkg::fdrf_byte_t seq_in,
    input wire logic seq_out_ready,
    output logic seq_in_ready,
    output fdrf_pkg::fdrf_byte_t seq_out,
    output logic floppy_dma_request,
    output logic floppy_service_interrupt,
    output logic host_request_flag,
    output logic transfer_direction_flag,
    output logic dir_low_released,
    output logic [1:0] rate_code,
    output logic [9:0] rate_kbps
);
    import fdrf_pkg::*;

    // Address match, shared by every strobe decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Bit rate in kbps for a code; FM halves the MFM rates except the 1M code, which stays 1000
    function automatic logic [9:0] kbps(input logic [1:0] c, input logic fm);
        case (c)
            `FDRF_CODE_1M: kbps = `FDRF_K1000;
            `FDRF_CODE_500: kbps = fm ? `FDRF_K250 : `FDRF_K500;
            `FDRF_CODE_300: kbps = fm ? `FDRF_K150 : `FDRF_K300;
            default: kbps = fm ? `FDRF_K125 : `FDRF_K250;
        endcase
    endfunction

    logic [7:0] mem [0:15]; // Byte buffer storage
    logic [3:0] wp; // Fill index
    logic [3:0] rp; // Drain index
    logic [4:0] cnt; // Bytes held
    logic [3:0] cfg_thr; // Buffer threshold
    logic cfg_en; // Buffer enable
    logic cfg_lock; // Keep enable over soft reset
    logic cfg_nonburst; // Gap between requests
    logic cfg_dis_rd; // No buffer on reads
    logic cfg_dis_wr; // No buffer on writes
    logic no_precomp_bit; // Stored, no effect on precompensation
    logic soft_rst; // Self-clearing soft reset pulse
    logic dchg_s1; // Pin synchroniser stage one
    logic dchg; // Synchronised disk change
    fdrf_req_t fsm; // Request sequencer
    fdrf_req_t next_fsm;
    logic [5:0] gap_cnt; // Cycles left in the gap

    // Bus strobes; one wait state
    wire acc = psel & penable & ~pready;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_data = wr & hit(paddr, `FDRF_A_DATA);
    wire rd_data = rd & hit(paddr, `FDRF_A_DATA);
    wire wr_ccr = wr & hit(paddr, `FDRF_A_CCR);
    wire wr_dsr = wr & hit(paddr, `FDRF_A_DSR);
    wire wr_cfg = wr & hit(paddr, `FDRF_A_CFG);
    wire rd_dir = rd & hit(paddr, `FDRF_A_DIR);
    wire mapped = hit(paddr, `FDRF_A_DATA) | hit(paddr, `FDRF_A_MSR) | hit(paddr, `FDRF_A_DIR)
                  | hit(paddr, `FDRF_A_CCR) | hit(paddr, `FDRF_A_DSR) | hit(paddr, `FDRF_A_CFG);

    // Full depth only for enabled execution transfers
    wire exec = (seq_phase == PH_EXEC);
    wire dir_off = seq_dir ? cfg_dis_rd : cfg_dis_wr;
    wire buf_on = cfg_en & exec & ~dir_off;
    wire [4:0] cap = buf_on ? `FDRF_DEPTH : 5'h01;
    wire [3:0] thr_eff = buf_on ? cfg_thr : 4'h0;
    wire room = cnt < cap;
    wire held = cnt != 5'h00;

    // Fill and drain; direction picks the sides
    wire out_free = ~seq_out.valid | seq_out_ready;
    wire push = room & (seq_dir ? (seq_in.valid & seq_in_ready) : wr_data);
    wire pop = held & (seq_dir ? rd_data : out_free);
    wire [7:0] push_byte = seq_dir ? seq_in.data : pwdata[7:0];
    wire [4:0] next_cnt = cnt + {4'h0, push} - {4'h0, pop};
    wire host_ready = seq_dir ? held : room;
    wire host_xfer = seq_dir ? rd_data : wr_data;

    // Service need; threshold sets latency slack
    wire [4:0] free = cap - cnt;
    wire need = exec & (seq_dir ? (cnt > {1'b0, thr_eff}) : (free > {1'b0, thr_eff}));
    wire done = seq_dir ? ~held : ~room;

    // Register views
    wire density = rate_code[1] ^ rate_code[0];
    wire [7:0] msr_val = {host_request_flag, transfer_direction_flag, exec & ~dma_enable_bit,
                          seq_phase != PH_CMD, 4'h0};
    wire [7:0] dir_at = {dchg, 7'h00};
    wire [7:0] dir_ps2 = {dchg, 4'hF, rate_code, density};
    wire [7:0] dir_m30 = {~dchg, 3'h0, dma_enable_bit, no_precomp_bit, rate_code};
    wire [7:0] dir_val = (compat_mode == MODE_PS2) ? dir_ps2 :
                         (compat_mode == MODE_M30) ? dir_m30 : dir_at;
    wire [8:0] cfg_val = {cfg_dis_wr, cfg_dis_rd, cfg_nonburst, cfg_lock, cfg_en, cfg_thr};
    wire [7:0] data_val = held ? mem[rp] : 8'h00;
    wire [31:0] rd_mux = hit(paddr, `FDRF_A_DATA) ? {24'h0, data_val} :
                         hit(paddr, `FDRF_A_MSR) ? {24'h0, msr_val} :
                         hit(paddr, `FDRF_A_DIR) ? {24'h0, dir_val} :
                         hit(paddr, `FDRF_A_CFG) ? {23'h0, cfg_val} : 32'h0;
    // Illegal FM code leaves the rate where it was
    wire rate_ok = ~(fm_mode & (pwdata[1:0] == `FDRF_CODE_1M));

    // Request sequencer next state
    always_comb begin
        next_fsm = fsm;
        case (fsm)
            REQ_IDLE: begin
                if (need) begin
                    next_fsm = REQ_SERVE;
                end
            end
            REQ_SERVE: begin
                // Burst holds until drained or filled
                if (!exec) begin
                    next_fsm = REQ_IDLE;
                end else if (host_xfer && cfg_nonburst) begin
                    next_fsm = REQ_GAP;
                end else if (done) begin
                    next_fsm = REQ_IDLE;
                end
            end
            REQ_GAP: begin
                if (!exec) begin
                    next_fsm = REQ_IDLE;
                end else if (gap_cnt == 6'h00) begin
                    next_fsm = done ? REQ_IDLE : REQ_SERVE;
                end
            end
            default: next_fsm = REQ_IDLE;
        endcase
    end
    wire next_req = (next_fsm == REQ_SERVE) & ~soft_rst;

    // Disk change pin synchroniser; soft reset does not touch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dchg_s1 <= 1'b0;
            dchg <= 1'b0;
        end else begin
            dchg_s1 <= disk_change_input;
            dchg <= dchg_s1; // power_down does not gate it; it keeps tracking the pin
        end
    end

    // APB answer, read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            dir_low_released <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc & ~mapped;
            prdata <= rd ? rd_mux : 32'h0;
            // Bits 6..0 belong to the shared disk status in legacy mode
            dir_low_released <= rd_dir & (compat_mode == MODE_AT);
        end
    end

    // Buffer configuration; only a hard reset clears it outright
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_thr <= 4'h0;
            cfg_en <= 1'b0;
            cfg_lock <= 1'b0;
            cfg_nonburst <= 1'b0;
            cfg_dis_rd <= 1'b0;
            cfg_dis_wr <= 1'b0;
        end else if (soft_rst) begin
            cfg_en <= cfg_en & cfg_lock;
        end else if (wr_cfg) begin
            cfg_thr <= pwdata[3:0];
            cfg_en <= pwdata[`FDRF_B_EN];
            cfg_lock <= pwdata[`FDRF_B_LOCK];
            cfg_nonburst <= pwdata[`FDRF_B_NONBURST];
            cfg_dis_rd <= pwdata[`FDRF_B_DISRD];
            cfg_dis_wr <= pwdata[`FDRF_B_DISWR];
        end
    end

    // Rate and no-precomp; upper bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_code <= `FDRF_RATE_RST;
            no_precomp_bit <= 1'b0;
            soft_rst <= 1'b0;
            rate_kbps <= `FDRF_K250;
        end else begin
            soft_rst <= wr_dsr & pwdata[`FDRF_B_SWRST];
            if ((wr_ccr || wr_dsr) && rate_ok) begin
                rate_code <= pwdata[1:0];
            end
            if (wr_ccr && compat_mode == MODE_M30) begin
                no_precomp_bit <= pwdata[`FDRF_B_NO_PRECOMP_BIT];
            end
            rate_kbps <= kbps(rate_code, fm_mode);
        end
    end

    // Indices and count; soft reset empties
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= 4'h0;
            rp <= 4'h0;
            cnt <= 5'h00;
        end else if (soft_rst) begin
            wp <= 4'h0;
            rp <= 4'h0;
            cnt <= 5'h00;
        end else begin
            wp <= wp + {3'h0, push};
            rp <= rp + {3'h0, pop};
            cnt <= next_cnt;
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wp] <= push_byte;
        end
    end

    // Sequencer side handshakes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_out <= '0;
            seq_in_ready <= 1'b0;
        end else if (soft_rst) begin
            seq_out <= '0;
            seq_in_ready <= 1'b0;
        end else begin
            // Ready looks one count ahead
            seq_in_ready <= seq_dir & (next_cnt < cap);
            if (pop && !seq_dir) begin
                seq_out <= '{valid: 1'b1, data: mem[rp]};
            end else if (seq_out_ready) begin
                seq_out.valid <= 1'b0;
            end
        end
    end

    // Request flag drops after every byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_request_flag <= 1'b0;
            transfer_direction_flag <= 1'b0;
        end else begin
            host_request_flag <= host_ready & ~host_xfer & ~soft_rst;
            transfer_direction_flag <= seq_dir;
        end
    end

    // Service request sequencer and gap timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsm <= REQ_IDLE;
            gap_cnt <= 6'h00;
            floppy_dma_request <= 1'b0;
            floppy_service_interrupt <= 1'b0;
        end else begin
            fsm <= soft_rst ? REQ_IDLE : next_fsm;
            if (next_fsm == REQ_GAP && fsm != REQ_GAP) begin
                gap_cnt <= `FDRF_GAP_CYC - 6'h01;
            end else if (gap_cnt != 6'h00) begin
                gap_cnt <= gap_cnt - 6'h01;
            end
            // One request, DMA or interrupt
            floppy_dma_request <= next_req & dma_enable_bit;
            floppy_service_interrupt <= next_req & ~dma_enable_bit;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire req_any = floppy_dma_request | floppy_service_interrupt;

    chk_rate_last_write: assert property ((wr_ccr || wr_dsr) && rate_ok |=> rate_code == $past(pwdata[1:0]))
        else $error("rate code did not follow last write");
    chk_illegal_fm: assert property ((wr_ccr || wr_dsr) && !rate_ok |=> $stable(rate_code))
        else $error("illegal FM code changed the rate");
    chk_rqm_clears: assert property (host_xfer |=> !host_request_flag)
        else $error("request flag not cleared after byte");

    chk_dir_flag: assert property (##1 transfer_direction_flag == $past(seq_dir))
        else $error("direction flag wrong");

    chk_gap_low: assert property (fsm == REQ_SERVE && exec && host_xfer && cfg_nonburst && !soft_rst
        |=> !req_any [*8])
        else $error("request not dropped in gap");
    chk_gap_len: assert property (fsm == REQ_GAP |-> gap_cnt < `FDRF_GAP_CYC)
        else $error("gap counter out of range");

    chk_burst_hold: assert property (fsm == REQ_SERVE && exec && !cfg_nonburst && !done && !soft_rst
        |=> req_any)
        else $error("burst request dropped early");

    chk_bypass_one: assert property (!exec && held |-> !push)
        else $error("buffer used outside execution");
    chk_lock_keeps: assert property (soft_rst && cfg_lock && cfg_en |=> cfg_en)
        else $error("locked buffer disabled by soft reset");

    chk_ps2_layout: assert property (rd_dir && compat_mode == MODE_PS2
        |=> prdata[6:3] == 4'hF && prdata[0] == $past(density) && prdata[2:1] == $past(rate_code))
        else $error("second layout wrong");
    chk_m30_layout: assert property (rd_dir && compat_mode == MODE_M30
        |=> prdata[6:4] == 3'h0 && prdata[3] == $past(dma_enable_bit) && prdata[7] == !$past(dchg))
        else $error("third layout wrong");
    chk_at_layout: assert property (rd_dir && compat_mode == MODE_AT
        |=> prdata[6:0] == 7'h00 && dir_low_released)
        else $error("legacy layout drives low bits");

    chk_density: assert property (rate_code == `FDRF_CODE_1M || rate_code == `FDRF_CODE_500 |-> !density)
        else $error("density flag wrong");


    cov_burst: cover property (fsm == REQ_SERVE && !cfg_nonburst && cnt == `FDRF_DEPTH);
    cov_gap: cover property (fsm == REQ_GAP ##1 fsm == REQ_SERVE);
    cov_soft_lock: cover property (soft_rst && cfg_lock && cfg_en);
    cov_ps2_read: cover property (rd_dir && compat_mode == MODE_PS2);
endmodule

// [verilog/fdrf_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts
 * for the floppy rate, data port and input register bank.
 * Assumes a 100 MHz APB clock and byte offsets on a 32-bit bus.
 */
`ifndef FDRF_REGS_SVH
`define FDRF_REGS_SVH
`define FDRF_A_DATA 8'h00
`define FDRF_A_MSR 8'h04
`define FDRF_A_DIR 8'h08
`define FDRF_A_CCR 8'h0C
`define FDRF_A_DSR 8'h10
`define FDRF_A_CFG 8'h14
`define FDRF_DEPTH 5'h10
`define FDRF_CLK_NS 10
`define FDRF_GAP_NS 350
`define FDRF_GAP_CYC 6'((`FDRF_GAP_NS + `FDRF_CLK_NS - 1) / `FDRF_CLK_NS)
`define FDRF_RATE_RST 2'h2
`define FDRF_CODE_1M 2'h3
`define FDRF_CODE_500 2'h0
`define FDRF_CODE_300 2'h1
`define FDRF_K1000 10'h3E8
`define FDRF_K500 10'h1F4
`define FDRF_K300 10'h12C
`define FDRF_K250 10'h0FA
`define FDRF_K150 10'h096
`define FDRF_K125 10'h07D
`define FDRF_B_SWRST 7
`define FDRF_B_NO_PRECOMP_BIT 2
`define FDRF_B_EN 4
`define FDRF_B_LOCK 5
`define FDRF_B_NONBURST 6
`define FDRF_B_DISRD 7
`define FDRF_B_DISWR 8
`endif

// [verilog/fdrf_pkg.sv]
/*
 * Types shared by the floppy register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fdrf_pkg;
    // Service request sequencer, one-hot
    typedef enum logic [2:0] {REQ_IDLE = 3'b001, REQ_SERVE = 3'b010, REQ_GAP = 3'b100} fdrf_req_t;
    // Phase reported by the command sequencer
    typedef enum logic [1:0] {PH_CMD = 2'h0, PH_EXEC = 2'h1, PH_RES = 2'h2} fdrf_phase_t;
    // Static register layout selection
    typedef enum logic [1:0] {MODE_AT = 2'h0, MODE_PS2 = 2'h1, MODE_M30 = 2'h2} fdrf_mode_t;
    // One byte with its valid mark
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fdrf_byte_t;
endpackage

// [sim/fdrf_seq_model.sv]
/*
 * Behavioural command sequencer facing the data port of fdrf_core.
 * Assumes the core's pclk domain and its byte handshake on seq_in and seq_out.
 */
`timescale 1ns/1ps
module fdrf_seq_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [4:0] fill_n,
    input wire logic [7:0] fill_base,
    input wire logic stall,
    input wire logic slow,
    input wire logic seq_in_ready,
    input wire fdrf_pkg::fdrf_byte_t seq_out,
    output fdrf_pkg::fdrf_byte_t seq_in,
    output logic seq_out_ready,
    output logic [7:0] last_taken,
    output logic [7:0] taken_count,
    output logic [4:0] pending
);
    import fdrf_pkg::*;
    logic [7:0] next_data; // Byte offered next
    logic toggle; // Acceptance phase in slow mode
    // Idle bus shows the inverse so stale data never matches
    assign seq_in = {pending != 5'h00, (pending != 5'h00) ? next_data : ~next_data};
    // Slow takes every other cycle; stall holds
    assign seq_out_ready = !stall && (!slow || toggle);
    // Deliver bytes, drain host writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 5'h00;
            next_data <= 8'h00;
            toggle <= 1'b0;
            last_taken <= 8'h00;
            taken_count <= 8'h00;
        end else begin
            toggle <= ~toggle;
            if (load) begin
                pending <= fill_n;
                next_data <= fill_base;
            end else if (seq_in.valid && seq_in_ready) begin
                pending <= pending - 5'h01;
                next_data <= next_data + 8'h01;
            end
            if (seq_out.valid && seq_out_ready) begin
                last_taken <= seq_out.data;
                taken_count <= taken_count + 8'h01;
            end
        end
    end
endmodule

// [sim/floppy_rate_fifo_input_regs_tb_top.sv]
/*
 * Self-checking bench for fdrf_core: APB tasks and test sequences.
 * Assumes the register map and one-wait-state APB answer of the core.
 */
`timescale 1ns/1ps
`include "fdrf_regs.svh"
module floppy_rate_fifo_input_regs_tb_top;
    import fdrf_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, got_err, got_rel, got_rqm;
    logic disk_change_input = 1'b0, dma_enable_bit = 1'b0, fm_mode = 1'b0, seq_dir = 1'b0;
    fdrf_mode_t compat_mode = MODE_AT; // Layout select
    fdrf_phase_t seq_phase = PH_CMD; // Sequencer phase
    fdrf_byte_t seq_in, seq_out;
    logic seq_in_ready, seq_out_ready, floppy_dma_request, floppy_service_interrupt;
    logic host_request_flag, transfer_direction_flag, dir_low_released;
    logic [1:0] rate_code;
    logic [9:0] rate_kbps;
    logic load = 1'b0, stall = 1'b0, slow = 1'b0; // Sequencer model controls
    logic [4:0] fill_n = 5'h00, pending;
    logic [7:0] fill_base = 8'h00, last_taken, taken_count, base;
    int err_count = 0, total_checks = 0, cycles = 0, n;
    fdrf_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .disk_change_input(disk_change_input), .power_down(1'b0), .dma_enable_bit(dma_enable_bit),
        .fm_mode(fm_mode), .compat_mode(compat_mode), .seq_phase(seq_phase), .seq_dir(seq_dir),
        .seq_in(seq_in), .seq_out_ready(seq_out_ready), .seq_in_ready(seq_in_ready), .seq_out(seq_out),
        .floppy_dma_request(floppy_dma_request), .floppy_service_interrupt(floppy_service_interrupt),
        .host_request_flag(host_request_flag), .transfer_direction_flag(transfer_direction_flag),
        .dir_low_released(dir_low_released), .rate_code(rate_code), .rate_kbps(rate_kbps));
    fdrf_seq_model u_seq (.pclk(pclk), .presetn(presetn), .load(load), .fill_n(fill_n),
        .fill_base(fill_base), .stall(stall), .slow(slow), .seq_in_ready(seq_in_ready), .seq_out(seq_out),
        .seq_in(seq_in), .seq_out_ready(seq_out_ready), .last_taken(last_taken),
        .taken_count(taken_count), .pending(pending));
    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("ERROR timeout expected finish seen none");
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        got_err = pslverr;
        got_rel = dir_low_released;
        got_rqm = host_request_flag;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) cmp("apb answer", 32'h1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(a, 1'b0, 32'h0);
    endtask
    // Poll status until a byte is wanted
    task automatic poll_rqm;
        int k;
        k = 0;
        do begin
            rdr(`FDRF_A_MSR);
            k++;
        end while (rd[7] !== 1'b1 && k < 20);
    endtask
    task automatic fill(input logic [4:0] cnt, input logic [7:0] b);
        load <= 1'b1;
        fill_n <= cnt;
        fill_base <= b;
        @(posedge pclk);
        load <= 1'b0;
    endtask
    // Hard reset for 10 cycles, then defaults
    task automatic hard_reset;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp("reset rate code", 32'h2, {30'h0, rate_code});
        cmp("reset kbps", 32'hFA, {22'h0, rate_kbps});
        rdr(`FDRF_A_CFG);
        cmp("reset buffer config", 32'h0, rd);
    endtask
    task automatic rate_check(input logic [7:0] a, input logic [31:0] d, input logic [1:0] c);
        wr(a, d);
        repeat (3) @(posedge pclk);
        cmp("active rate code", {30'h0, c}, {30'h0, rate_code});
    endtask
    function automatic logic [9:0] kbps_exp(input int f, input int c);
        logic [9:0] t [8] = '{10'h1F4, 10'h12C, 10'h0FA, 10'h3E8, 10'h0FA, 10'h096, 10'h07D, 10'h07D};
        return t[4 * f + c];
    endfunction
    function automatic logic [31:0] dir_exp(input int m, input logic dc, input logic [1:0] r, input logic de);
        case (m)
            0: return {24'h0, dc, 7'h00};
            1: return {24'h0, dc, 4'hF, r, (r == 2'h1 || r == 2'h2)};
            default: return {24'h0, ~dc, 3'h0, de, 1'b1, r};
        endcase
    endfunction
    initial begin
        hard_reset();
        rdr(8'h18);
        cmp("unmapped error", 32'h1, {31'h0, got_err});
        $display("test reset done");
        // All codes, MFM and FM; FM code 3 keeps the rate
        for (int f = 0; f < 2; f++) begin
            fm_mode <= f[0];
            for (int c = 0; c < 4; c++) begin
                rate_check(`FDRF_A_CCR, c, (f == 1 && c == 3) ? 2'h2 : c[1:0]);
                cmp("rate kbps", {22'h0, kbps_exp(f, c)}, {22'h0, rate_kbps});
            end
        end
        fm_mode <= 1'b0;
        rate_check(`FDRF_A_DSR, 32'h0, 2'h0);
        rate_check(`FDRF_A_CCR, 32'h3, 2'h3);
        $display("test rate done");
        // Three layouts, both change levels, both densities
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 2; r++) begin
                for (int d = 0; d < 2; d++) begin
                    compat_mode <= fdrf_mode_t'(m);
                    disk_change_input <= d[0];
                    dma_enable_bit <= ~d[0];
                    wr(`FDRF_A_CCR, (m == 2) ? 32'h4 + r : r);
                    repeat (4) @(posedge pclk);
                    rdr(`FDRF_A_DIR);
                    cmp("input register", dir_exp(m, d[0], r[1:0], ~d[0]), rd);
                    if (m == 0) begin
                        cmp("low bits released", 32'h1, {31'h0, got_rel});
                    end
                end
            end
        end
        $display("test input register done");
        // Soft reset keeps rate, no-precomp and a locked buffer enable
        for (int l = 1; l >= 0; l--) begin
            wr(`FDRF_A_CFG, l ? 32'h30 : 32'h10);
            wr(`FDRF_A_DSR, 32'h81);
            repeat (3) @(posedge pclk);
            rdr(`FDRF_A_DIR);
            cmp("input register kept", dir_exp(2, 1'b1, 2'h1, 1'b0), rd);
            cmp("rate kept", 32'h1, {30'h0, rate_code});
            rdr(`FDRF_A_CFG);
            cmp("buffer enable", l, {31'h0, rd[4]});
        end
        wr(`FDRF_A_CFG, 32'h3F);
        wr(`FDRF_A_CCR, 32'h0);
        hard_reset();
        $display("test resets done");
        // Command byte written through the data port reaches the sequencer
        repeat (3) @(posedge pclk);
        poll_rqm();
        cmp("status command", 32'h2, {30'h0, rd[7:6]});
        wr(`FDRF_A_DATA, 32'hA5);
        cmp("flag after byte", 32'h0, {31'h0, got_rqm});
        repeat (4) @(posedge pclk);
        cmp("command byte", 32'hA5, {24'h0, last_taken});
        // Result bytes bypass an enabled buffer
        wr(`FDRF_A_CFG, 32'h11);
        seq_phase <= PH_RES;
        seq_dir <= 1'b1;
        fill(5'h03, 8'h30);
        repeat (10) @(posedge pclk);
        cmp("result bypass", 32'h2, {27'h0, pending});
        for (int i = 0; i < 3; i++) begin
            poll_rqm();
            cmp("status result", 32'h3, {30'h0, rd[7:6]});
            rdr(`FDRF_A_DATA);
            cmp("result byte", 32'h30 + i, rd);
        end
        $display("test command and result done");
        // Burst read through a full 16-byte buffer with DMA requests
        wr(`FDRF_A_CFG, 32'h13);
        dma_enable_bit <= 1'b1;
        seq_phase <= PH_EXEC;
        fill(5'h10, 8'h40);
        repeat (40) @(posedge pclk);
        cmp("buffer filled", 32'h0, {27'h0, pending});
        for (int i = 0; i < 16; i++) begin
            cmp("burst request held", 32'h1, {31'h0, floppy_dma_request});
            rdr(`FDRF_A_DATA);
            cmp("burst byte", 32'h40 + i, rd);
        end
        repeat (3) @(posedge pclk);
        cmp("burst request dropped", 32'h0, {31'h0, floppy_dma_request});
        // Non-burst interrupt requests leave a gap after every byte
        wr(`FDRF_A_CFG, 32'h50);
        dma_enable_bit <= 1'b0;
        fill(5'h04, 8'h60);
        for (int i = 0; i < 4; i++) begin
            n = 0;
            while (floppy_service_interrupt !== 1'b1 && n < 200) begin
                @(posedge pclk);
                n++;
            end
            if (i > 0) begin
                cmp("non-burst gap", 32'h1, {31'h0, n >= 34 && n < 200});
            end
            rdr(`FDRF_A_DATA);
            cmp("non-burst byte", 32'h60 + i, rd);
        end
        $display("test execution read done");
        // Write-disabled buffer holds one byte plus output stage
        seq_dir <= 1'b0;
        slow <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            stall <= 1'b1;
            wr(`FDRF_A_CFG, k ? 32'h11 : 32'h111);
            base = taken_count;
            for (int i = 0; i < 3; i++) begin
                wr(`FDRF_A_DATA, 32'h70 + i);
            end
            stall <= 1'b0;
            repeat (20) @(posedge pclk);
            cmp("bytes written through", k ? 32'h3 : 32'h2, {24'h0, taken_count - base});
        end
        $display("test execution write done");
        tally_and_finish();
    end
endmodule
